// *** pkg/nvsp_pkg.sv ***
package nvsp_pkg;

    // ----------------------------------------------------------------
    // widths of the word-wide build
    // ----------------------------------------------------------------
    localparam int ADDR_W = 17;
    localparam int DATA_W = 16;

    // ----------------------------------------------------------------
    // timing, in ns and in 100 MHz cycles
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_ACCESS_NS   = 45;    // slowest access grade
    localparam int T_WR_PULSE_NS = 30;    // least write strobe width
    localparam int T_HW_PULL_NS  = 50;    // least save request pull
    localparam int T_ONSET_NS    = 1000;  // longest wait for busy to show
    localparam int SYNC_STAGES   = 2;

    localparam int ACCESS_CYC  = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RD_WAIT_CYC = ACCESS_CYC + SYNC_STAGES;
    localparam int WR_CYC      = (T_WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HW_PULL_CYC = (T_HW_PULL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ONSET_CYC   = T_ONSET_NS / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // software save address sequence, entry 0 first
    // ----------------------------------------------------------------
    localparam int SEQ_LEN = 6;
    localparam logic [2:0] SEQ_LAST = 3'h5;
    localparam logic [SEQ_LEN-1:0][ADDR_W-1:0] SEQ_ADDR = {
        17'h08FC0, 17'h0703F, 17'h07C1F, 17'h083E0, 17'h0B1C7, 17'h04E38
    };

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef logic [7:0] nvsp_cnt_t;

    typedef enum logic [1:0] {
        OP_READ,
        OP_WRITE,
        OP_SW_SAVE,
        OP_HW_SAVE
    } nvsp_op_t;

    typedef struct packed {
        nvsp_op_t            op;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
        logic                upper_byte_lane_n;
        logic                lower_byte_lane_n;
    } nvsp_cmd_t;

    typedef struct packed {
        logic [ADDR_W-1:0]   addr;
        logic                chip_select_n;
        logic                output_drive_n;
        logic                write_strobe_n;
        logic                upper_byte_lane_n;
        logic                lower_byte_lane_n;
    } nvsp_pins_t;

    localparam nvsp_pins_t PINS_IDLE = '{
        addr: 17'h00000, chip_select_n: 1'h1, output_drive_n: 1'h1,
        write_strobe_n: 1'h1, upper_byte_lane_n: 1'h1, lower_byte_lane_n: 1'h1
    };
    localparam logic [DATA_W:0] SYNC_RST = 17'h10000;  // busy line idles high

endpackage : nvsp_pkg

// *** testbench/nonvolatile_sram_port_tb_top.sv ***
`timescale 1ns/1ps
module nonvolatile_sram_port_tb_top;
    localparam int SAVE_CYC = 20;
    nvsp_pkg::nvsp_cmd_t  cmd;
    nvsp_pkg::nvsp_pins_t pins;
    logic        clk, reset_n, cmd_valid, power_low, flip, cmd_ready, rsp_valid, rsp_timeout;
    logic        save_busy, busy_drv, busy_en_n, dq_en_n, dev_pull;
    logic [15:0] rsp_rdata, dq_val, dev_dq, dq_bus, r16;
    logic [1:0]  dev_oe, line_hist;
    logic [31:0] xs;
    logic [16:0] a;
    logic [15:0] ref_m [int];
    int          n_fail, samples_checked, n_save, n_bad, n_rdy_bad, base;
    wire busy_line = !(dev_pull || (!busy_en_n && !busy_drv));
    // undriven bytes toggle so a stale value never passes
    assign dq_bus[15:8] = dev_oe[1] ? dev_dq[15:8] : !dq_en_n ? dq_val[15:8] : {8{flip}};
    assign dq_bus[7:0]  = dev_oe[0] ? dev_dq[7:0] : !dq_en_n ? dq_val[7:0] : {8{~flip}};
    nvsp_host_ctrl DUT (.clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .rsp_timeout(rsp_timeout), .save_busy(save_busy), .pins(pins), .dq_drv_val(dq_val),
        .dq_drv_en_n(dq_en_n), .dq_pin_val(dq_bus), .nv_save_busy_n_pin(busy_line),
        .nv_save_busy_drv(busy_drv), .nv_save_busy_drv_en_n(busy_en_n));
    nvsp_dev_model #(.SAVE_CYC(SAVE_CYC), .GRACE(3)) u_dev (.clk(clk), .reset_n(reset_n),
        .pins(pins), .dq(dq_bus), .busy_line(busy_line), .power_low(power_low),
        .dev_dq(dev_dq), .dev_oe(dev_oe), .dev_pull(dev_pull), .n_save(n_save), .n_bad(n_bad));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) flip <= ~flip;
    // line level two edges back, what the controller may act on
    always @(posedge clk) line_hist <= {line_hist[0], busy_line};
    function automatic logic [31:0] rnd();
        xs = xs ^ (xs << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
        return xs;
    endfunction : rnd
    function automatic logic [15:0] lane_mask(input logic [1:0] ln);
        return {{8{!ln[1]}}, {8{!ln[0]}}};
    endfunction : lane_mask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test
    task automatic do_cmd(input nvsp_pkg::nvsp_op_t op, input logic [16:0] ad,
                          input logic [15:0] d, input logic [1:0] ln);
        int k;
        cmd_valid <= 1'b1;
        cmd <= '{op: op, addr: ad, wdata: d, upper_byte_lane_n: ln[1], lower_byte_lane_n: ln[0]};
        k = 0;
        do begin
            @(posedge clk);
            k++;
            if ((save_busy === 1'b1 || line_hist[1] === 1'b0) && cmd_ready !== 1'b0) n_rdy_bad++;
        end while (cmd_ready !== 1'b1 && k < 2000);
        cmd_valid <= 1'b0;
        do begin
            @(posedge clk);
            k++;
        end while (rsp_valid !== 1'b1 && k < 4000);
        if (rsp_valid !== 1'b1) begin
            n_fail++;
            $display("ERROR rsp_valid expected 1 seen none");
            end_of_test();
        end
    endtask : do_cmd
    task automatic wr(input logic [16:0] ad, input logic [15:0] d, input logic [1:0] ln);
        r16 = ref_m.exists(int'(ad)) ? ref_m[int'(ad)] : 16'h0000;
        ref_m[int'(ad)] = (r16 & ~lane_mask(ln)) | (d & lane_mask(ln));
        do_cmd(nvsp_pkg::OP_WRITE, ad, d, ln);
    endtask : wr
    task automatic rd_chk(input logic [16:0] ad, input logic [1:0] ln);
        do_cmd(nvsp_pkg::OP_READ, ad, 16'h0000, ln);
        r16 = ref_m.exists(int'(ad)) ? ref_m[int'(ad)] : 16'h0000;
        check("read data", rsp_rdata & lane_mask(ln), r16 & lane_mask(ln));
    endtask : rd_chk
    initial begin
        {reset_n, cmd_valid, power_low, flip} = 4'h0;
        cmd = '0;
        xs = 32'h00000044;
        {n_fail, samples_checked, n_rdy_bad} = '0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        // ----------------------------------------------------------------
        // random access, lane mixes, both address ends
        // ----------------------------------------------------------------
        for (int i = 0; i < 24; i++) begin
            xs = rnd();
            a = (i < 2) ? {17{i[0]}} : {xs[16], 11'h000, xs[4:0]};
            wr(a, xs[31:16], xs[6:5]);
            rd_chk(a, xs[8:7] & {~xs[8], 1'b1});
            xs = rnd();
            rd_chk({xs[16], 11'h000, xs[4:0]}, 2'h0);
        end
        $display("test random_access done");
        // ----------------------------------------------------------------
        // pin save, dirty then clean
        // ----------------------------------------------------------------
        base = n_save;
        wr(17'h00010, 16'hBEEF, 2'h0);
        do_cmd(nvsp_pkg::OP_HW_SAVE, 17'h00000, 16'h0000, 2'h3);
        check("saves after dirty pin request", n_save, base + 1);
        do_cmd(nvsp_pkg::OP_HW_SAVE, 17'h00000, 16'h0000, 2'h3);
        check("saves after clean pin request", n_save, base + 1);
        rd_chk(17'h00010, 2'h0);
        $display("test pin_save done");
        // ----------------------------------------------------------------
        // software save runs even when clean
        // ----------------------------------------------------------------
        for (int i = 0; i < 2; i++) begin
            do_cmd(nvsp_pkg::OP_SW_SAVE, 17'h00000, 16'h0000, 2'h0);
            check("busy onset timeout", rsp_timeout, 1'b0);
        end
        check("saves after software saves", n_save, base + 3);
        $display("test soft_save done");
        // ----------------------------------------------------------------
        // supply loss, dirty then clean; read held off
        // ----------------------------------------------------------------
        xs = rnd();
        wr(17'h00011, xs[15:0], 2'h0);
        power_low <= 1'b1;
        repeat (5) @(posedge clk);
        rd_chk(17'h00011, 2'h0);
        check("saves after supply loss", n_save, base + 4);
        power_low <= 1'b0;
        @(posedge clk);
        power_low <= 1'b1;
        repeat (SAVE_CYC + 10) @(posedge clk);
        check("saves after clean supply loss", n_save, base + 4);
        $display("test supply_loss done");
        check("host pin faults", n_bad, 0);
        check("ready while busy", n_rdy_bad, 0);
        end_of_test();
    end
endmodule : nonvolatile_sram_port_tb_top

// *** testbench/nvsp_dev_model.sv ***
`timescale 1ns/1ps
module nvsp_dev_model #(
    parameter int SAVE_CYC = 20,  // save length, shortened
    parameter int GRACE    = 3    // pin save grace, cycles
) (
    input  wire logic            clk,       // bench sample clock
    input  wire logic            reset_n,   // power-on, active low
    input  nvsp_pkg::nvsp_pins_t pins,      // controller strobes
    input  wire logic [15:0]     dq,        // resolved data bus
    input  wire logic            busy_line, // resolved busy line
    input  wire logic            power_low, // supply under threshold
    output logic [15:0]          dev_dq,    // read data value
    output logic [1:0]           dev_oe,    // byte drivers on
    output logic                 dev_pull,  // busy line pulled low
    output int                   n_save,    // saves finished
    output int                   n_bad      // host pin faults
);
    localparam logic [15:0] SEQ_RD [6] = '{16'h4E38, 16'hB1C7, 16'h83E0,
                                           16'h7C1F, 16'h703F, 16'h8FC0};
    logic [15:0] mem [int];
    logic [15:0] old;
    logic [15:0] wd_q;
    logic [16:0] wa_q;
    logic [16:0] ra_q;
    logic [1:0]  wl_q;
    logic        wr_q, rd_q, pl_q, dirty, pf_en;
    int          save_t, grace_t, seq_i;
    wire rd = !pins.chip_select_n && !pins.output_drive_n && pins.write_strobe_n && busy_line;
    wire wr = !pins.chip_select_n && !pins.write_strobe_n && (busy_line || wr_q);
    always @* begin
        dev_oe = rd ? ~{pins.upper_byte_lane_n, pins.lower_byte_lane_n} : 2'h0;
        dev_dq = mem.exists(int'(pins.addr)) ? mem[int'(pins.addr)] : 16'h0000;
    end
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pf_en = 1'b1;
            {wr_q, rd_q, pl_q, dirty} = 4'h0;
            {save_t, grace_t, seq_i, n_save, n_bad} = '0;
            dev_pull <= 1'b0;
        end else begin
            if (wr_q && wr && pins.addr != wa_q) n_bad++;
            if (wr && !pins.output_drive_n) n_bad++;
            if (wr_q && !wr) begin
                old = mem.exists(int'(wa_q)) ? mem[int'(wa_q)] : 16'h0000;
                if (!wl_q[1]) old[15:8] = wd_q[15:8];
                if (!wl_q[0]) old[7:0] = wd_q[7:0];
                mem[int'(wa_q)] = old;
                dirty = 1'b1;
                seq_i = 0;
            end
            if (rd_q && !rd) begin
                if (ra_q[15:0] == SEQ_RD[seq_i]) begin
                    seq_i = (seq_i == 5) ? 0 : seq_i + 1;
                    if (seq_i == 0) save_t = SAVE_CYC;
                end else begin
                    seq_i = (ra_q[15:0] == SEQ_RD[0]) ? 1 : 0;
                end
            end
            if (!busy_line && save_t == 0) begin
                grace_t++;
                if (grace_t == GRACE && dirty) save_t = SAVE_CYC;
            end else begin
                grace_t = 0;
            end
            if (power_low && !pl_q && pf_en && dirty && save_t == 0) save_t = SAVE_CYC;
            // whole array, busy low then high
            if (save_t > 0) begin
                save_t--;
                if (save_t == 0) begin
                    dirty = 1'b0;
                    n_save++;
                end
            end
            wr_q = wr;
            rd_q = rd;
            pl_q = power_low;
            if (wr) {wa_q, wd_q, wl_q} = {pins.addr, dq,
                                          pins.upper_byte_lane_n, pins.lower_byte_lane_n};
            if (rd) ra_q = pins.addr;
            // nba: the busy line must not race the host's sampling edge
            dev_pull <= (save_t > 0);
        end
    end
endmodule : nvsp_dev_model

// *** verilog/nvsp_host_ctrl.sv ***
// Notes on behaviour
// - read: select, output low; strobe, busy high
// - write: select, strobe low; busy high
// - address steady through whole write
// - output drive kept high during writes
// - busy line low during every save
// - strobe held inactive out of reset
// - six fixed reads start software save
`timescale 1ns/1ps
module nvsp_host_ctrl (
    input  wire logic                clk,                 // 100 MHz clock
    input  wire logic                reset_n,             // async reset, active low
    input  wire logic                cmd_valid,           // command offered
    input  nvsp_pkg::nvsp_cmd_t      cmd,                 // command fields
    output logic                     cmd_ready,           // command taken when valid
    output logic                     rsp_valid,           // one-cycle completion pulse
    output logic [15:0]              rsp_rdata,           // last read data
    output logic                     rsp_timeout,         // save never showed busy
    output logic                     save_busy,           // busy line seen low
    output nvsp_pkg::nvsp_pins_t     pins,                // address and strobes
    output logic [15:0]              dq_drv_val,          // data toward device
    output logic                     dq_drv_en_n,         // data drive, low drives
    input  wire logic [15:0]         dq_pin_val,          // data pin levels
    input  wire logic                nv_save_busy_n_pin,  // busy line level
    output logic                     nv_save_busy_drv,    // busy line drive value
    output logic                     nv_save_busy_drv_en_n // busy pull, low pulls
);
    typedef enum logic [2:0] {
        S_IDLE, S_READ, S_WRITE, S_GAP, S_HW_PULL, S_WAIT_LOW, S_WAIT_HIGH
    } nvsp_state_t;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    nvsp_state_t          state_q, state_d;
    nvsp_pkg::nvsp_pins_t pins_q, pins_d;
    nvsp_pkg::nvsp_cnt_t  cnt_q, cnt_d;
    logic [15:0]          wdata_q, wdata_d, rdata_q, rdata_d;
    logic [2:0]           seq_q, seq_d;
    logic                 sw_q, sw_d, dq_en_q, dq_en_d, pull_q, pull_d;
    logic                 done_q, done_d, tmo_q, tmo_d;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [16:0] sync_lvl;
    nvsp_sync2 #(.W(17), .RST_VAL(nvsp_pkg::SYNC_RST)) u_sync (
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in ({nv_save_busy_n_pin, dq_pin_val}),
        .sync_out (sync_lvl)
    );

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire        busy_high = sync_lvl[16];
    wire [15:0] dq_sync   = sync_lvl[15:0];
    wire        cnt_zero  = (cnt_q == 8'h00);
    wire [7:0]  cnt_dec   = cnt_q - 8'h01;
    wire [2:0]  seq_nx    = seq_q + 3'h1;
    wire        seq_more  = sw_q && (seq_q != nvsp_pkg::SEQ_LAST);
    // a new command only starts with the busy line high
    // read gated by busy
    wire        take      = cmd_valid && cmd_ready;

    assign cmd_ready             = (state_q == S_IDLE) && busy_high;
    assign rsp_valid             = done_q;
    assign rsp_rdata             = rdata_q;
    assign rsp_timeout           = tmo_q;
    assign save_busy             = !busy_high;
    assign pins                  = pins_q;
    assign dq_drv_val            = wdata_q;
    assign dq_drv_en_n           = !dq_en_q;
    assign nv_save_busy_drv      = 1'h0;
    assign nv_save_busy_drv_en_n = !pull_q;

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        pins_d  = pins_q;
        cnt_d   = cnt_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        seq_d   = seq_q;
        sw_d    = sw_q;
        dq_en_d = dq_en_q;
        pull_d  = pull_q;
        done_d  = 1'h0;
        tmo_d   = tmo_q;
        case (state_q)
            S_IDLE: begin
                if (take) begin
                    tmo_d                    = 1'h0;
                    pins_d.addr              = cmd.addr;
                    pins_d.upper_byte_lane_n = cmd.upper_byte_lane_n;
                    pins_d.lower_byte_lane_n = cmd.lower_byte_lane_n;
                    case (cmd.op)
                        nvsp_pkg::OP_READ: begin
                            pins_d.chip_select_n  = 1'h0;
                            pins_d.output_drive_n = 1'h0;
                            cnt_d   = nvsp_pkg::nvsp_cnt_t'(nvsp_pkg::RD_WAIT_CYC - 1);
                            state_d = S_READ;
                        end
                        nvsp_pkg::OP_WRITE: begin
                            pins_d.chip_select_n  = 1'h0;
                            pins_d.write_strobe_n = 1'h0;
                            wdata_d = cmd.wdata;
                            dq_en_d = 1'h1;
                            cnt_d   = nvsp_pkg::nvsp_cnt_t'(nvsp_pkg::WR_CYC - 1);
                            state_d = S_WRITE;
                        end
                        nvsp_pkg::OP_SW_SAVE: begin
                            pins_d.addr           = nvsp_pkg::SEQ_ADDR[0];
                            pins_d.chip_select_n  = 1'h0;
                            pins_d.output_drive_n = 1'h0;
                            seq_d   = 3'h0;
                            sw_d    = 1'h1;
                            cnt_d   = nvsp_pkg::nvsp_cnt_t'(nvsp_pkg::RD_WAIT_CYC - 1);
                            state_d = S_READ;
                        end
                        default: begin
                            pull_d  = 1'h1;
                            cnt_d   = nvsp_pkg::nvsp_cnt_t'(nvsp_pkg::HW_PULL_CYC - 1);
                            state_d = S_HW_PULL;
                        end
                    endcase
                end
            end
            S_READ: begin
                if (cnt_zero) begin
                    rdata_d               = dq_sync;
                    pins_d.chip_select_n  = 1'h1;
                    pins_d.output_drive_n = 1'h1;
                    state_d               = S_GAP;
                end else begin
                    cnt_d = cnt_dec;
                end
            end
            S_WRITE: begin
                if (cnt_zero) begin
                    pins_d.chip_select_n  = 1'h1;
                    pins_d.write_strobe_n = 1'h1;
                    state_d               = S_GAP;
                end else begin
                    cnt_d = cnt_dec;
                end
            end
            S_GAP: begin
                // data held one cycle past the closing edge
                dq_en_d = 1'h0;
                if (seq_more) begin
                    seq_d                 = seq_nx;
                    pins_d.addr           = nvsp_pkg::SEQ_ADDR[seq_nx];
                    pins_d.chip_select_n  = 1'h0;
                    pins_d.output_drive_n = 1'h0;
                    cnt_d   = nvsp_pkg::nvsp_cnt_t'(nvsp_pkg::RD_WAIT_CYC - 1);
                    state_d = S_READ;
                end else if (sw_q) begin
                    sw_d    = 1'h0;
                    cnt_d   = nvsp_pkg::nvsp_cnt_t'(nvsp_pkg::ONSET_CYC - 1);
                    state_d = S_WAIT_LOW;
                end else begin
                    done_d  = 1'h1;
                    state_d = S_IDLE;
                end
            end
            S_HW_PULL: begin
                if (cnt_zero) begin
                    pull_d  = 1'h0;
                    state_d = S_WAIT_HIGH;
                end else begin
                    cnt_d = cnt_dec;
                end
            end
            S_WAIT_LOW: begin
                if (!busy_high || cnt_zero) begin
                    tmo_d   = busy_high;
                    state_d = S_WAIT_HIGH;
                end else begin
                    cnt_d = cnt_dec;
                end
            end
            S_WAIT_HIGH: begin
                // watch busy line until save ends
                if (busy_high) begin
                    done_d  = 1'h1;
                    state_d = S_IDLE;
                end
            end
            default: state_d = S_IDLE;
        endcase
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // strobe inactive from reset on
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= S_IDLE;
            pins_q  <= nvsp_pkg::PINS_IDLE;
            cnt_q   <= 8'h00;
            wdata_q <= 16'h0000;
            rdata_q <= 16'h0000;
            seq_q   <= 3'h0;
            {sw_q, dq_en_q, pull_q, done_q, tmo_q} <= 5'h00;
        end else begin
            state_q <= state_d;
            pins_q  <= pins_d;
            cnt_q   <= cnt_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            seq_q   <= seq_d;
            {sw_q, dq_en_q, pull_q, done_q, tmo_q} <= {sw_d, dq_en_d, pull_d, done_d, tmo_d};
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    AST_READ_STROBE_HIGH: assert property (
        !pins_q.chip_select_n && !pins_q.output_drive_n |-> pins_q.write_strobe_n)
        else $error("read with write strobe low");
    AST_START_BUSY_HIGH: assert property (
        $fell(pins_q.chip_select_n) && $past(state_q == S_IDLE) |-> $past(busy_high))
        else $error("access started while busy line low");
    AST_WRITE_PULSE: assert property (
        $fell(pins_q.write_strobe_n)
        |-> (!pins_q.write_strobe_n && !pins_q.chip_select_n)[*3] ##1 pins_q.write_strobe_n)
        else $error("write strobe width wrong");
    AST_WRITE_ADDR_HOLD: assert property (
        !pins_q.write_strobe_n |=> $stable(pins_q.addr))
        else $error("address moved during write");
    AST_WRITE_OE_HIGH: assert property (
        !pins_q.write_strobe_n |-> pins_q.output_drive_n && !dq_drv_en_n)
        else $error("output drive low or data not driven in write");
    AST_IDLE_STROBE: assert property (
        state_q == S_IDLE |-> pins_q.write_strobe_n && pins_q.chip_select_n)
        else $error("strobes active while idle");
    AST_SEQ_ADDR: assert property (
        $fell(pins_q.chip_select_n) && sw_q |-> pins_q.addr == nvsp_pkg::SEQ_ADDR[seq_q])
        else $error("sequence address out of order");
    AST_SEQ_NO_WRITE: assert property (
        sw_q |-> pins_q.write_strobe_n && dq_drv_en_n)
        else $error("write inside save sequence");
    AST_HW_PULL_WIDTH: assert property (
        $fell(nv_save_busy_drv_en_n)
        |-> (!nv_save_busy_drv_en_n)[*5] ##1 nv_save_busy_drv_en_n ##1 state_q == S_WAIT_HIGH)
        else $error("save request pull width wrong");
endmodule : nvsp_host_ctrl

// *** verilog/nvsp_sync2.sv ***
`timescale 1ns/1ps
module nvsp_sync2 #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk,      // system clock
    input  wire logic         reset_n,  // async reset, active low
    input  wire logic [W-1:0] async_in, // pin levels
    output logic      [W-1:0] sync_out  // levels after two flops
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q   <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : nvsp_sync2
